// File: src/ezb_pkg.sv
// shared constants and types of the external zone bus interface
// assumes one 20 MHz clock and a 32-bit APB register port
package ezb_pkg;

    // register byte offsets
    localparam logic [7:0] EZB_OFS_CONFIG = 8'h00;
    localparam logic [7:0] EZB_OFS_ZONE0  = 8'h04;
    localparam logic [7:0] EZB_OFS_ZONE6  = 8'h08;
    localparam logic [7:0] EZB_OFS_ZONE7  = 8'h0c;
    localparam logic [7:0] EZB_OFS_STATUS = 8'h10;

    // configuration bits
    localparam int EZB_CFG_HALF_RATE  = 0;
    localparam int EZB_CFG_RELEASE_EN = 1;
    localparam int EZB_CFG_POST_EN    = 2;
    localparam logic [2:0] EZB_CFG_RESET = 3'h3;

    // status bits
    localparam int EZB_ST_REQ   = 0;
    localparam int EZB_ST_GRANT = 1;
    localparam int EZB_ST_BUSY  = 2;

    localparam int EZB_ZONES     = 3;
    localparam int EZB_ZONE_BITS = 19;
    localparam logic [1:0] EZB_WIDTH_16 = 2'h3;
    localparam logic [1:0] EZB_WIDTH_32 = 2'h1;

    // ready sample points, in interface ticks before the end of the active period
    localparam logic [7:0] EZB_SYNC_SAMPLE  = 8'h01;
    localparam logic [7:0] EZB_ASYNC_SAMPLE = 8'h03;

    typedef struct packed {
        logic [1:0] rdLead;
        logic [2:0] rdActive;
        logic [1:0] rdTrail;
        logic [1:0] wrLead;
        logic [2:0] wrActive;
        logic [1:0] wrTrail;
        logic       readyEn;
        logic       asyncSel;
        logic       dbl;
        logic [1:0] width;
    } ezb_zone_t;

    localparam ezb_zone_t EZB_ZONE_RESET = '{
        rdLead: 2'h3, rdActive: 3'h7, rdTrail: 2'h3,
        wrLead: 2'h3, wrActive: 3'h7, wrTrail: 2'h3,
        readyEn: 1'b1, asyncSel: 1'b1, dbl: 1'b1, width: 2'h3};

    typedef struct packed {
        logic        write;
        logic        wide;
        logic [1:0]  zone;
        logic [19:0] addr;
        logic [31:0] wdata;
    } ezb_req_t;

    typedef enum logic [2:0] {EZB_IDLE, EZB_LEAD, EZB_ACTIVE, EZB_TRAIL, EZB_HOLD} ezb_state_t;

endpackage : ezb_pkg

// File: src/ezb_top.sv
// external zone bus interface: zone timing, width strobes, bus release
// assumes synchronous inputs on clk, a cpu that release_request_status its request until
// cpuReady, and an outside master that keeps its release request until granted
//
// Chosen here: the APB interface to the registers and the address map.

// Notes on behaviour
// R01: 16-bit zone: pin is address bit zero
// R02: 32-bit zone: 16-bit half write strobes, idle high
// R03: release request: finish accesses, then grant
// R04: granted: all interface outputs floated
// R05: release enable bit gates request granting
// R06: granted: cpu external accesses stall
// R07: release request disables write posting
// R08: request synchronised, no reset on flops
// R09: status shows synced request and grant
// R10: reset sets release enable; grant works
// R11: pending cpu cycles blocked until release
// R12: outside master release_request_status request until grant
// R13: lead equals count, doubled optionally
// R14: active equals count plus waits plus one
// R15: trail equals count, doubled optionally
// R16: ready waits zero when ready ignored
// R17: per-zone timing and ready sampling
// R18: illegal timing values used unchecked
// R19: ignored ready needs lead at least one
// R20: synchronous ready needs lead, active >=1
// R21: ready enable plus async select: async
// R22: low ready extends active by one
// R23: sample ready one or three before end
// R24: width 3 is 16-bit, 1 is 32-bit
// R25: interface tick full or half rate
// R26: request removed: ungrant, drive, then resume
module ezb_top
    import ezb_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // cpu memory bus
    input  wire logic        cpuReq,
    input  wire ezb_req_t    cpuCmd,
    output logic             cpuReady,
    output logic [31:0]      cpuRdata,
    // external memory pins
    output logic [19:1]      address_bus,
    output logic             addressOe,
    input  wire logic [31:0] dataIn,
    output logic [31:0]      dataOut,
    output logic             dataOe,
    output logic             low_address_or_upper_write_strobe,
    output logic             lowAddrOe,
    output logic             lower_write_strobe_n,
    output logic             read_strobe_n,
    output logic             read_write_line,
    output logic             strobeOe,
    output logic [2:0]       zoneChipSelect_n,
    output logic             chipSelectOe,
    input  wire logic        external_ready_in,
    // outside bus master
    input  wire logic        bus_release_request_n,
    output logic             bus_release_grant_n
);

    logic [2:0]  config_q;
    ezb_zone_t   zoneCfg [EZB_ZONES];
    logic        reqMeta;
    logic        reqSync;
    logic        tickPhase;
    logic        tick;
    ezb_state_t  state;
    ezb_req_t    cur;
    ezb_zone_t   zc;
    logic        curPosted;
    logic [7:0]  cnt;
    logic        holdPend;
    logic        accept;
    logic        postNow;
    logic        done;
    logic        sampleNow;
    logic [1:0]  zoneIdx;
    logic        apbSetup;
    logic        mapped;
    logic [7:0]  leadTicks;
    logic [7:0]  activeTicks;
    logic [7:0]  trailTicks;
    logic [7:0]  sampleAt;
    logic        granted;
    logic        lowAddrHeld;

    // R08 two-stage synchroniser without reset
    always_ff @(posedge clk) begin
        reqMeta <= bus_release_request_n;
        reqSync <= reqMeta;
    end

    // R25 interface tick at full or half rate
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tickPhase <= 1'b0;
        end else begin
            tickPhase <= ~tickPhase;
        end
    end
    assign tick = config_q[EZB_CFG_HALF_RATE] ? tickPhase : 1'b1;

    // apb register port, zero wait states
    assign apbSetup = psel && !penable;
    assign pready   = 1'b1;
    assign mapped   = (paddr == EZB_OFS_CONFIG) || (paddr == EZB_OFS_ZONE0)
                   || (paddr == EZB_OFS_ZONE6) || (paddr == EZB_OFS_ZONE7)
                   || (paddr == EZB_OFS_STATUS);
    assign pslverr  = psel && penable && !mapped;

    // R10 release enable comes up set
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            config_q <= EZB_CFG_RESET;
        end else if (psel && penable && pwrite && paddr == EZB_OFS_CONFIG) begin
            config_q <= pwdata[2:0];
        end
    end

    // R17 one timing register per zone
    for (genvar z = 0; z < EZB_ZONES; z++) begin : g_zone
        localparam logic [7:0] OFS = EZB_OFS_ZONE0 + 8'(4 * z);
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                zoneCfg[z] <= EZB_ZONE_RESET;
            end else if (psel && penable && pwrite && paddr == OFS) begin
                zoneCfg[z] <= ezb_zone_t'(pwdata[EZB_ZONE_BITS-1:0]);
            end
        end
    end

    // R09 status read back
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0;
        end else if (apbSetup && !pwrite) begin
            unique case (paddr)
                EZB_OFS_CONFIG: prdata <= {29'h0, config_q};
                EZB_OFS_ZONE0:  prdata <= {13'h0, zoneCfg[0]};
                EZB_OFS_ZONE6:  prdata <= {13'h0, zoneCfg[1]};
                EZB_OFS_ZONE7:  prdata <= {13'h0, zoneCfg[2]};
                EZB_OFS_STATUS: prdata <= {29'h0, state != EZB_IDLE && !granted,
                                           bus_release_grant_n, reqSync};
                default:        prdata <= 32'h0;
            endcase
        end
    end

    // R05 enable bit overrides the request
    assign holdPend = config_q[EZB_CFG_RELEASE_EN] && !reqSync;
    assign granted  = state == EZB_HOLD;

    // zone 3 folds onto the last zone
    assign zoneIdx = (cpuCmd.zone > 2'(EZB_ZONES - 1)) ? 2'(EZB_ZONES - 1) : cpuCmd.zone;
    assign zc      = zoneCfg[(cur.zone > 2'(EZB_ZONES - 1)) ? 2'(EZB_ZONES - 1) : cur.zone];

    // R13 R15 lead and trail, doubled when selected
    // R18 values taken as written
    always_comb begin
        leadTicks   = 8'(cur.write ? zc.wrLead : zc.rdLead) << zc.dbl;
        trailTicks  = 8'(cur.write ? zc.wrTrail : zc.rdTrail) << zc.dbl;
        // R14 active plus the implied cycle
        activeTicks = (8'(cur.write ? zc.wrActive : zc.rdActive) << zc.dbl) + 8'h01;
        // R21 R23 sample point by ready mode
        sampleAt    = zc.asyncSel ? EZB_ASYNC_SAMPLE : EZB_SYNC_SAMPLE;
    end

    // R11 R06 no new cycle once release is pending or granted
    assign accept  = tick && state == EZB_IDLE && cpuReq && !holdPend;
    // R07 posting only while no release request
    assign postNow = cpuCmd.write && config_q[EZB_CFG_POST_EN] && reqSync;
    // R16 ready ignored means no waits
    assign sampleNow = zc.readyEn && cnt == sampleAt;
    assign done = tick && ((state == EZB_TRAIL && cnt <= 8'h01)
               || (state == EZB_ACTIVE && !(sampleNow && !external_ready_in)
                   && cnt <= 8'h01 && trailTicks == 8'h00));
    assign cpuReady = (accept && postNow) || (done && !curPosted);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state     <= EZB_IDLE;
            cnt       <= 8'h00;
            cur       <= '0;
            curPosted <= 1'b0;
        end else if (tick) begin
            unique case (state)
                EZB_IDLE: begin
                    // R03 grant only with nothing outstanding
                    if (holdPend) begin
                        state <= EZB_HOLD;
                    end else if (accept) begin
                        cur       <= cpuCmd;
                        curPosted <= postNow;
                        state     <= EZB_LEAD;
                        cnt       <= 8'h00;
                    end
                end
                EZB_LEAD: begin
                    if (cnt + 8'h01 >= leadTicks) begin
                        state <= EZB_ACTIVE;
                        cnt   <= activeTicks;
                    end else begin
                        cnt <= cnt + 8'h01;
                    end
                end
                EZB_ACTIVE: begin
                    // R22 low ready release_request_status the count one tick
                    if (sampleNow && !external_ready_in) begin
                        cnt <= cnt;
                    end else if (cnt <= 8'h01) begin
                        state <= (trailTicks == 8'h00) ? EZB_IDLE : EZB_TRAIL;
                        cnt   <= trailTicks;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                EZB_TRAIL: begin
                    if (cnt <= 8'h01) begin
                        state <= EZB_IDLE;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                EZB_HOLD: begin
                    // R26 leave hold before any new access
                    if (!holdPend) begin
                        state <= EZB_IDLE;
                    end
                end
            endcase
        end
    end

    // read data latched at the end of the active period
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cpuRdata <= 32'h0;
        end else if (tick && state == EZB_ACTIVE && !cur.write && cnt <= 8'h01
                     && !(sampleNow && !external_ready_in)) begin
            cpuRdata <= dataIn;
        end
    end

    // address and data held in flops; the shared pin comes from a flop only in 16-bit zones
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            address_bus <= 19'h0;
            dataOut     <= 32'h0;
        end else if (accept) begin
            address_bus <= cpuCmd.addr[19:1];
            dataOut     <= cpuCmd.wdata;
        end
    end

    // R01 R24 16-bit zone: pin keeps last address bit zero, set as the access starts
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lowAddrHeld <= 1'b1;
        end else if (accept && zoneCfg[zoneIdx].width == EZB_WIDTH_16) begin
            lowAddrHeld <= cpuCmd.addr[0];
        end
    end

    // R02 upper strobe for odd 16-bit or 32-bit writes, in step with the lower one
    assign low_address_or_upper_write_strobe = (zc.width == EZB_WIDTH_16) ? lowAddrHeld
        : !(state == EZB_ACTIVE && cur.write && (cur.wide || cur.addr[0]));

    // R02 lower strobe for every 16-bit zone write and for even or 32-bit writes, idle high
    assign lower_write_strobe_n = !(state == EZB_ACTIVE && cur.write
                                    && (zc.width == EZB_WIDTH_16 || cur.wide || !cur.addr[0]));
    assign read_strobe_n   = !(state == EZB_ACTIVE && !cur.write);
    assign read_write_line = !(cur.write && state != EZB_IDLE && state != EZB_HOLD);

    for (genvar z = 0; z < EZB_ZONES; z++) begin : g_cs
        assign zoneChipSelect_n[z] = !((state == EZB_LEAD || state == EZB_ACTIVE
                                        || state == EZB_TRAIL) && zc == zoneCfg[z]
                                       && (cur.zone == 2'(z)
                                           || (z == EZB_ZONES - 1 && cur.zone == 2'h3)));
    end

    // R04 everything floated while granted
    assign addressOe    = !granted;
    assign lowAddrOe    = !granted;
    assign strobeOe     = !granted;
    assign chipSelectOe = !granted;
    assign dataOe       = !granted && cur.write && (state == EZB_ACTIVE || state == EZB_TRAIL);

    // R03 R10 grant follows the hold state
    assign bus_release_grant_n = !granted;

endmodule : ezb_top

// File: tb/ezb_assertions.sv
// checker of ezb_top pins during access and bus release
// assumes a bind to each ezb_top instance
module ezb_assertions (
    // clock and reset
    input wire logic       clk,
    input wire logic       arst_n,
    // watched pins
    input wire logic       cpuReady,
    input wire logic       addressOe,
    input wire logic       dataOe,
    input wire logic       strobeOe,
    input wire logic       chipSelectOe,
    input wire logic [2:0] zoneChipSelect_n,
    input wire logic       read_strobe_n,
    input wire logic       lower_write_strobe_n,
    input wire logic       read_write_line,
    input wire logic       bus_release_request_n,
    input wire logic       bus_release_grant_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence held;
        !bus_release_grant_n;
    endsequence
    sequence freed;
        bus_release_request_n [*6];
    endsequence
    pins_float_a: assert property (
        held |-> !(addressOe | dataOe | strobeOe | chipSelectOe)) else $error("pin driven");
    cpu_stalled_a: assert property (held |-> !cpuReady) else $error("ready in hold");
    request_synced_a: assert property (
        $fell(bus_release_grant_n) |-> !$past(bus_release_request_n, 2)) else $error("early");
    access_done_a: assert property (
        $fell(bus_release_grant_n) |-> $past(zoneChipSelect_n) == 3'h7) else $error("cs");
    bus_resumed_a: assert property (
        held ##0 freed |-> bus_release_grant_n) else $error("grant stuck");
    read_strobe_a: assert property (
        !read_strobe_n |-> read_write_line && lower_write_strobe_n) else $error("rd");
    write_strobe_a: assert property (
        !lower_write_strobe_n |-> !read_write_line && read_strobe_n) else $error("wr");
    zone_select_a: assert property (
        !(read_strobe_n && lower_write_strobe_n) |-> $onehot(~zoneChipSelect_n))
        else $error("zone select");
    cover property (held ##0 freed);
endmodule : ezb_assertions

bind ezb_top ezb_assertions chk (.*);

// File: tb/ezb_partner.sv
// model of the external memory and the outside bus master
// assumes the bench sets stallLen between accesses and holdGo at any time
module ezb_partner (
    // bench control
    input  wire logic        clk,
    input  wire logic [3:0]  stallLen,
    input  wire logic        holdGo,
    // device pins
    input  wire logic [19:1] address_bus,
    input  wire logic        read_strobe_n,
    input  wire logic        lower_write_strobe_n,
    input  wire logic        bus_release_grant_n,
    output logic [31:0]      dataIn,
    output logic             external_ready_in,
    output logic             bus_release_request_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0]  lowCnt = 4'h0;
    logic [31:0] last = 32'h0;
    // released data lines show the inverse of the last word
    assign dataIn = read_strobe_n ? ~last : {13'h0, address_bus};
    // ready low for the first stallLen strobe cycles
    assign external_ready_in = lowCnt >= stallLen;
    initial bus_release_request_n = 1'b1;
    always @(posedge clk) begin
        if (!read_strobe_n)
            last <= dataIn;
        lowCnt <= (read_strobe_n && lower_write_strobe_n) ? 4'h0 : lowCnt + 4'(lowCnt != 4'hf);
    end
    always @(posedge clk)
        bus_release_request_n <= !(holdGo || (!bus_release_request_n && bus_release_grant_n));
endmodule : ezb_partner

// File: tb/test_external_zone_bus_interface.sv
// bench of ezb_top: strobes, access timing, ready waits, bus release
// assumes ezb_partner and the bound checker are compiled alongside
module test_external_zone_bus_interface
    import ezb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, cpuReq = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, cpuRdata, dataIn, dataOut, rd;
    ezb_req_t    cpuCmd = '0;
    logic [3:0]  stallLen = 4'h0;
    logic        holdGo = 0, is32 = 0, readySeen = 0, err;
    logic        pready, pslverr, cpuReady, addressOe, dataOe, lowAddrOe, strobeOe;
    logic        low_address_or_upper_write_strobe, lower_write_strobe_n, read_strobe_n;
    logic        read_write_line, chipSelectOe, external_ready_in;
    logic        bus_release_request_n, bus_release_grant_n;
    logic [19:1] address_bus;
    logic [2:0]  zoneChipSelect_n;
    logic [1:0]  wePair;
    int          failures = 0, samples_checked = 0, nLead, nAct, nTrail, a1, a2, a3;
    ezb_top dut (.*);
    ezb_partner mem (.*);
    always #25 clk = ~clk;
    // period counters of the access in flight
    always @(posedge clk) begin
        if (cpuReady === 1'b1)
            readySeen <= 1'b1;
        if (zoneChipSelect_n != 3'h7) begin
            if (!(read_strobe_n && lower_write_strobe_n && (!is32 || low_address_or_upper_write_strobe))) begin
                nAct <= nAct + 1;
                wePair <= {low_address_or_upper_write_strobe, lower_write_strobe_n};
            end else if (nAct == 0)
                nLead <= nLead + 1;
            else
                nTrail <= nTrail + 1;
        end
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task setz(input logic [7:0] o, input ezb_zone_t z);
        apb(1, o, {13'h0, z});
    endtask : setz
    task cpu(input logic w, input logic wide, input logic [1:0] z, input logic [19:0] a);
        int n;
        @(posedge clk);
        nLead <= 0;
        nAct <= 0;
        nTrail <= 0;
        cpuReq <= 1;
        cpuCmd <= '{w, wide, z, a, 32'h0000a5c3};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (cpuReady !== 1'b1 && n < 300);
        cpuReq <= 0;
        chk("cpu done", 1, n < 300);
        repeat (4) @(posedge clk);
    endtask : cpu
    task waitg(input logic v);
        for (int n = 0; n < 200 && bus_release_grant_n !== v; n++) @(posedge clk);
        chk("grant", v, bus_release_grant_n);
    endtask : waitg
    task rdy(input logic en, input logic as, input logic [3:0] s, output int a);
        setz(EZB_OFS_ZONE7, '{2'h1, 3'h2, 2'h0, 2'h1, 3'h2, 2'h0, en, as, 1'b0, EZB_WIDTH_16});
        stallLen <= s;
        cpu(0, 0, 2'h2, 20'h00002);
        a = nAct;
    endtask : rdy
    task t_reset;
        apb(0, EZB_OFS_CONFIG, 0);
        chk("config", {29'h0, EZB_CFG_RESET}, rd);
        apb(0, EZB_OFS_ZONE0, 0);
        chk("zone0", {13'h0, EZB_ZONE_RESET}, rd);
        apb(0, EZB_OFS_STATUS, 0);
        chk("status", 32'h3, rd);
        apb(0, 8'h14, 0);
        chk("unmapped", 1, err);
    endtask : t_reset
    task t_width;
        apb(1, EZB_OFS_CONFIG, 32'h2);
        setz(EZB_OFS_ZONE0, '{2'h1, 3'h1, 2'h1, 2'h2, 3'h2, 2'h1, 1'b0, 1'b0, 1'b0, EZB_WIDTH_16});
        setz(EZB_OFS_ZONE6, '{2'h1, 3'h1, 2'h1, 2'h2, 3'h2, 2'h1, 1'b0, 1'b0, 1'b0, EZB_WIDTH_32});
        cpu(1, 0, 2'h0, 20'h00010);
        chk("a0 even", 0, wePair[1]);
        chk("wr periods", 24'h020301, {nLead[7:0], nAct[7:0], nTrail[7:0]});
        cpu(1, 0, 2'h0, 20'h00011);
        chk("a0 held", 1, low_address_or_upper_write_strobe);
        cpu(0, 0, 2'h0, 20'h00246);
        chk("rd data", 32'h0123, cpuRdata & 32'hffff);
        chk("rd periods", 24'h010201, {nLead[7:0], nAct[7:0], nTrail[7:0]});
        is32 <= 1;
        for (int i = 0; i < 3; i++) begin
            cpu(1, i == 2, 2'h1, 20'h00010 | 20'(i & 1));
            chk("strobes", 2'b10 >> i, wePair);
        end
        chk("idle", 2'b11, {low_address_or_upper_write_strobe, lower_write_strobe_n});
        is32 <= 0;
    endtask : t_width
    // ignored, sync and async ready with active of two, then half rate doubled
    task t_ready;
        rdy(0, 0, 4'h6, a1);
        chk("ignored", 3, a1);
        rdy(1, 0, 4'h5, a1);
        rdy(1, 0, 4'h6, a2);
        chk("one wait", 1, a2 - a1);
        rdy(1, 1, 4'h6, a3);
        chk("async", 2, a3 - a2);
        stallLen <= 0;
        apb(1, EZB_OFS_CONFIG, 32'h3);
        setz(EZB_OFS_ZONE7, '{2'h1, 3'h2, 2'h1, 2'h1, 3'h2, 2'h1, 1'b0, 1'b0, 1'b1, EZB_WIDTH_16});
        cpu(0, 0, 2'h2, 20'h00002);
        chk("half dbl", 24'h040a04, {nLead[7:0], nAct[7:0], nTrail[7:0]});
        apb(1, EZB_OFS_CONFIG, 32'h2);
    endtask : t_ready
    task t_release;
        fork
            begin
                repeat (3) @(posedge clk);
                holdGo <= 1;
            end
        join_none
        cpu(0, 0, 2'h0, 20'h00246);
        waitg(0);
        chk("oe", 0, {addressOe, dataOe, lowAddrOe, strobeOe, chipSelectOe});
        apb(0, EZB_OFS_STATUS, 0);
        chk("status", 0, rd);
        apb(1, EZB_OFS_CONFIG, 32'h6);
        cpuCmd.write <= 1'b1;
        cpuReq <= 1;
        readySeen <= 0;
        repeat (20) @(posedge clk);
        chk("stalled", 0, readySeen);
        holdGo <= 0;
        waitg(1);
        for (int n = 0; n < 100 && cpuReady !== 1'b1; n++) @(posedge clk);
        cpuReq <= 0;
        repeat (4) @(posedge clk);
        chk("resumed", 1, readySeen);
        apb(1, EZB_OFS_CONFIG, 32'h0);
        holdGo <= 1;
        repeat (30) @(posedge clk);
        chk("disabled", 1, bus_release_grant_n);
        apb(1, EZB_OFS_CONFIG, 32'h2);
        waitg(0);
        holdGo <= 0;
        waitg(1);
        holdGo <= 1;
        arst_n <= 0;
        repeat (6) @(posedge clk);
        arst_n <= 1;
        waitg(0);
        holdGo <= 0;
        waitg(1);
    endtask : t_release
    task finish_test;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1;
        t_reset;
        t_width;
        t_ready;
        t_release;
        finish_test;
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        finish_test;
    end
endmodule : test_external_zone_bus_interface
